// File: design/overcurrent_integrator.sv
// Sub-cycle overcurrent magnitude and time-current integration.
// Assumes samples arrive channel 0..3 per sample instant.
`timescale 1ns/1ps
`default_nettype none
module overcurrent_integrator (
  input wire logic core_clk,
  input wire logic reset_n,
  trip_curve_if.calc tc
);
  typedef struct packed {
    logic [3:0][15:0] dc;
    logic [3:0][15:0] pk;
    logic [3:0][15:0] mag;
    logic [31:0] acc;
  } integ_s;

  integ_s q;
  integ_s nxt_q;
  logic signed [16:0] dev;
  logic [15:0] dev_abs;
  logic [16:0] ex;
  logic [32:0] sum;

  localparam logic [4:0] PHASE_HALF_L = recloser_pkg::PHASE_HALF;
  localparam logic [4:0] PHASE_LAST_L = recloser_pkg::PHASE_LAST;
  localparam logic [3:0] CH_GROUND_L = recloser_pkg::CH_GROUND;

  function automatic logic [16:0] excess(input logic [15:0] mag,
                                         input logic [15:0] lim);
    excess = (mag > lim) ? ({1'b0, mag} - {1'b0, lim}) : 17'h0;
  endfunction : excess

  // ************************************************
  // Magnitude and integration
  // ************************************************
  always_comb begin
    nxt_q = q;
    dev = 17'(tc.smp_data) - 17'(signed'(q.dc[tc.smp_chan]));
    dev_abs = dev[16] ? 16'(-dev) : dev[15:0];
    ex = excess(q.mag[0], tc.min_trip_phase);
    for (int i = 1; i < 3; i++) begin
      if (excess(q.mag[i], tc.min_trip_phase) > ex) begin
        ex = excess(q.mag[i], tc.min_trip_phase);
      end
    end
    if (excess(q.mag[3], tc.min_trip_ground) > ex) begin
      ex = excess(q.mag[3], tc.min_trip_ground);
    end
    sum = {1'b0, q.acc} + 33'(ex);
    tc.above_min = (ex != 17'h0);
    tc.curve_done = tc.above_min && (q.acc >= tc.curve_limit);
    if (tc.smp_valid) begin
      // DC tracked by a slow average; deviation around it is the fundamental
      nxt_q.dc[tc.smp_chan] = q.dc[tc.smp_chan] + 16'(dev >>> recloser_pkg::DC_SHIFT);
      nxt_q.pk[tc.smp_chan] = (dev_abs > q.pk[tc.smp_chan]) ? dev_abs
                              : q.pk[tc.smp_chan];
      // Half-cycle peak window: sub-cycle response, harmonics mostly averaged
      if (tc.smp_phase == PHASE_HALF_L || tc.smp_phase == PHASE_LAST_L) begin
        nxt_q.mag[tc.smp_chan] = nxt_q.pk[tc.smp_chan];
        nxt_q.pk[tc.smp_chan] = 16'h0;
      end
    end
    if (tc.clear_acc || !tc.above_min) begin
      nxt_q.acc = 32'h0;
    end else if (tc.smp_valid && tc.smp_chan == 2'(CH_GROUND_L)) begin
      nxt_q.acc = sum[32] ? 32'hffff_ffff : sum[31:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= nxt_q;
    end
  end

  property p_acc_clear;
    @(posedge core_clk) disable iff (!reset_n)
      tc.clear_acc |=> (q.acc == 32'h0);
  endproperty
  a_acc_clear: assert property (p_acc_clear) else $error("accumulator not cleared");
endmodule : overcurrent_integrator
`default_nettype wire

// File: design/recloser_sequencer.sv
// Recloser trip and reclose sequencer with sampling front end.
// Assumes settings come straight from the non-volatile store
// and the mechanism reports open and closed on sense lines.
//
// Functional notes
// - Each analog input sampled 32 times per line cycle.
// - Protection current is sub-cycle, fundamental plus DC only.
// - Sequence starts only above minimum trip with curve timing elapsed.
// - First trip integrates overcurrent on the first curve, then trips.
// - Trip drive feeds solenoid from both battery and capacitor.
// - Recloser open starts the current reclosing interval.
// - Interval expiry closes and selects the next trip curve.
// - Current still above minimum after reclose repeats trip and reclose.
// - Persistent fault runs all recloses then locks out open.
// - Only panel or link close leaves lockout, back to start.
// - Closed and below minimum before lockout starts reset delay.
// - Reset delay expiry returns sequence to home.
// - Overcurrent during reset delay halts it, resumes, restarts count.
// - On battery, low battery voltage shuts the control down.
// - Control power loss resets time counter to the epoch.
// - Settings and records live in non-volatile storage.
// - AC indicator off after absence timeout, on at once on return.
// - Sixteen analog inputs, waveform kept for harmonics to 15th.
// - Three CT inputs, open and closed sense, trip and close drives.
// - Six voltage channels, three source side, three load side.
// - Analog results are 16 bits wide.
`timescale 1ns/1ps
`default_nettype none
module recloser_sequencer #(
  parameter logic [31:0] SAMPLE_CLKS = 32'(recloser_pkg::SAMPLE_CLKS),
  parameter logic [31:0] MS_CLKS = 32'(recloser_pkg::MS_CLKS),
  parameter logic [31:0] SEC_CLKS = 32'(recloser_pkg::SEC_CLKS),
  parameter logic [31:0] AC_OFF_CLKS = 32'(recloser_pkg::AC_OFF_CLKS)
) (
  input wire logic core_clk,
  input wire logic reset_n,
  output logic adc_start,
  output logic [3:0] adc_chan,
  input wire logic adc_valid,
  input wire logic signed [15:0] adc_data,
  input wire logic [8:0] wave_rd_addr,
  output logic [15:0] wave_rd_data,
  input wire logic [15:0] min_trip_phase,
  input wire logic [15:0] min_trip_ground,
  input wire logic [3:0][31:0] curve_limits,
  input wire logic [2:0][15:0] reclose_interval_ms,
  input wire logic [15:0] reset_delay_ms,
  input wire logic [2:0] trips_to_lockout,
  input wire logic open_sense,
  input wire logic closed_sense,
  input wire logic panel_close_req,
  input wire logic link_close_req,
  output logic trip_batt_drive,
  output logic trip_cap_drive,
  output logic close_drive,
  output logic lockout_ind,
  output logic above_min_ind,
  output logic [2:0] trip_count,
  input wire logic on_battery,
  input wire logic [15:0] battery_mv,
  output logic shutdown,
  input wire logic ctrl_power_lost,
  input wire logic rtc_set,
  input wire logic [31:0] rtc_value,
  output logic [31:0] rtc_seconds,
  input wire logic ac_present,
  output logic ac_led
);
  typedef struct packed {
    recloser_pkg::seq_state_e st;
    logic [2:0] ops;
    logic [31:0] tmr;
    logic [31:0] ms_cnt;
    logic [31:0] smp_cnt;
    logic [3:0] chan;
    logic [4:0] phase;
    logic start;
    logic [31:0] sec_cnt;
    logic [31:0] rtc;
    logic [31:0] ac_cnt;
    logic ac_led;
    logic shutdown;
  } seq_s;

  seq_s q;
  seq_s nxt_q;
  logic [15:0] wave_mem [512];
  logic [15:0] nxt_rd;
  logic ms_tick;
  logic close_req;
  logic last_trip;
  logic [31:0] interval;

  trip_curve_if tc ();

  overcurrent_integrator u_integ (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .tc(tc)
  );

  function automatic logic cnt_done(input logic [31:0] cnt, input logic [31:0] lim);
    cnt_done = (cnt >= lim - 32'h1);
  endfunction : cnt_done

  // ************************************************
  // Sampling front end
  // ************************************************
  assign tc.smp_valid = adc_valid && (q.chan <= recloser_pkg::CH_GROUND);
  assign tc.smp_chan = q.chan[1:0];
  assign tc.smp_phase = q.phase;
  assign tc.smp_data = adc_data;
  assign tc.min_trip_phase = min_trip_phase;
  assign tc.min_trip_ground = min_trip_ground;
  assign tc.curve_limit = curve_limits[q.ops[1:0]];
  assign tc.clear_acc = (q.st != recloser_pkg::ST_TIMING) &&
                        (q.st != recloser_pkg::ST_HOME);

  // Waveform store feeds the harmonic analyser; one word per channel and phase
  always_ff @(posedge core_clk) begin
    if (adc_valid) begin
      wave_mem[{q.chan, q.phase}] <= adc_data;
    end
  end

  assign nxt_rd = wave_mem[wave_rd_addr];

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wave_rd_data <= 16'h0;
    end else begin
      wave_rd_data <= nxt_rd;
    end
  end

  // ************************************************
  // Sequencer
  // ************************************************
  assign ms_tick = cnt_done(q.ms_cnt, MS_CLKS);
  assign close_req = panel_close_req || link_close_req;
  assign last_trip = (q.ops + 3'h1 >= trips_to_lockout) || (q.ops + 3'h1 >= recloser_pkg::MAX_OPS);
  assign interval = 32'(reclose_interval_ms[(q.ops == 3'h0) ? 2'h0 : 2'(q.ops - 3'h1)]);

  always_comb begin
    nxt_q = q;
    nxt_q.start = 1'b0;
    nxt_q.ms_cnt = ms_tick ? 32'h0 : q.ms_cnt + 32'h1;
    // Sample tick launches a 16-channel scan
    if (cnt_done(q.smp_cnt, SAMPLE_CLKS)) begin
      nxt_q.smp_cnt = 32'h0;
      nxt_q.chan = 4'h0;
      nxt_q.start = 1'b1;
    end else begin
      nxt_q.smp_cnt = q.smp_cnt + 32'h1;
      if (adc_valid) begin
        nxt_q.chan = q.chan + 4'h1;
        nxt_q.start = (q.chan != recloser_pkg::CH_LAST);
        if (q.chan == recloser_pkg::CH_LAST) begin
          nxt_q.phase = q.phase + 5'h1;
        end
      end
    end
    case (q.st)
      recloser_pkg::ST_HOME: begin
        nxt_q.ops = 3'h0;
        if (tc.above_min) begin
          nxt_q.st = recloser_pkg::ST_TIMING;
        end
      end
      recloser_pkg::ST_TIMING: begin
        if (tc.curve_done) begin
          nxt_q.st = recloser_pkg::ST_TRIP;
        end else if (!tc.above_min) begin
          nxt_q.tmr = 32'h0;
          nxt_q.st = (q.ops == 3'h0) ? recloser_pkg::ST_HOME
                     : recloser_pkg::ST_RESET_DELAY;
        end
      end
      recloser_pkg::ST_TRIP: begin
        if (open_sense) begin
          nxt_q.ops = q.ops + 3'h1;
          nxt_q.tmr = 32'h0;
          nxt_q.st = last_trip ? recloser_pkg::ST_LOCKOUT
                     : recloser_pkg::ST_RECLOSE_WAIT;
        end
      end
      recloser_pkg::ST_RECLOSE_WAIT: begin
        if (q.tmr >= interval) begin
          nxt_q.st = recloser_pkg::ST_CLOSE;
        end else if (ms_tick) begin
          nxt_q.tmr = q.tmr + 32'h1;
        end
      end
      recloser_pkg::ST_CLOSE: begin
        if (closed_sense) begin
          nxt_q.st = recloser_pkg::ST_TIMING;
        end
      end
      recloser_pkg::ST_RESET_DELAY: begin
        if (tc.above_min) begin
          nxt_q.tmr = 32'h0;
          nxt_q.st = recloser_pkg::ST_TIMING;
        end else if (q.tmr >= 32'(reset_delay_ms)) begin
          nxt_q.ops = 3'h0;
          nxt_q.st = recloser_pkg::ST_HOME;
        end else if (ms_tick) begin
          nxt_q.tmr = q.tmr + 32'h1;
        end
      end
      recloser_pkg::ST_LOCKOUT: begin
        if (close_req) begin
          nxt_q.ops = 3'h0;
          nxt_q.st = recloser_pkg::ST_CLOSE;
        end
      end
      default: begin
        nxt_q.st = recloser_pkg::ST_LOCKOUT;
      end
    endcase
    // ************************************************
    // Housekeeping: battery, time counter, AC indicator
    // ************************************************
    if (on_battery && battery_mv < recloser_pkg::BATT_LOW_MV) begin
      nxt_q.shutdown = 1'b1;
    end else if (!on_battery) begin
      nxt_q.shutdown = 1'b0;
    end
    if (ctrl_power_lost) begin
      nxt_q.rtc = recloser_pkg::RTC_EPOCH;
      nxt_q.sec_cnt = 32'h0;
    end else if (rtc_set) begin
      nxt_q.rtc = rtc_value;
      nxt_q.sec_cnt = 32'h0;
    end else if (cnt_done(q.sec_cnt, SEC_CLKS)) begin
      nxt_q.sec_cnt = 32'h0;
      nxt_q.rtc = q.rtc + 32'h1;
    end else begin
      nxt_q.sec_cnt = q.sec_cnt + 32'h1;
    end
    if (ac_present) begin
      nxt_q.ac_cnt = 32'h0;
      nxt_q.ac_led = 1'b1;
    end else if (cnt_done(q.ac_cnt, AC_OFF_CLKS)) begin
      nxt_q.ac_led = 1'b0;
    end else begin
      nxt_q.ac_cnt = q.ac_cnt + 32'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      q <= '0;
      q.st <= recloser_pkg::ST_HOME;
      q.rtc <= recloser_pkg::RTC_EPOCH;
    end else begin
      q <= nxt_q;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  assign adc_start = q.start;
  assign adc_chan = q.chan;
  assign trip_batt_drive = (q.st == recloser_pkg::ST_TRIP);
  assign trip_cap_drive = (q.st == recloser_pkg::ST_TRIP);
  assign close_drive = (q.st == recloser_pkg::ST_CLOSE);
  assign lockout_ind = (q.st == recloser_pkg::ST_LOCKOUT);
  assign above_min_ind = tc.above_min;
  assign trip_count = q.ops;
  assign shutdown = q.shutdown;
  assign rtc_seconds = q.rtc;
  assign ac_led = q.ac_led;

  // ************************************************
  // Assertions
  // ************************************************
  property p_trip_cause;
    @(posedge core_clk) disable iff (!reset_n)
      $rose(trip_batt_drive) |-> $past(tc.curve_done && tc.above_min);
  endproperty
  a_trip_cause: assert property (p_trip_cause) else $error("trip without curve");

  property p_both_sources;
    @(posedge core_clk) disable iff (!reset_n)
      trip_batt_drive == trip_cap_drive;
  endproperty
  a_both_sources: assert property (p_both_sources) else $error("trip sources split");

  property p_open_starts;
    @(posedge core_clk) disable iff (!reset_n)
      trip_batt_drive && open_sense |=> !trip_batt_drive && q.tmr == 32'h0;
  endproperty
  a_open_starts: assert property (p_open_starts) else $error("interval not started");

  property p_interval_close;
    @(posedge core_clk) disable iff (!reset_n)
      q.st == recloser_pkg::ST_RECLOSE_WAIT && q.tmr >= interval |=> close_drive;
  endproperty
  a_interval_close: assert property (p_interval_close) else $error("no reclose");

  property p_lockout_holds;
    @(posedge core_clk) disable iff (!reset_n)
      lockout_ind && !close_req |=> lockout_ind && !close_drive;
  endproperty
  a_lockout_holds: assert property (p_lockout_holds) else $error("left lockout");

  property p_lockout_close;
    @(posedge core_clk) disable iff (!reset_n)
      lockout_ind && close_req |=> close_drive && trip_count == 3'h0;
  endproperty
  a_lockout_close: assert property (p_lockout_close) else $error("close ignored");

  property p_reset_start;
    @(posedge core_clk) disable iff (!reset_n)
      q.st == recloser_pkg::ST_TIMING && !tc.curve_done && !tc.above_min &&
      q.ops != 3'h0 |=> q.st == recloser_pkg::ST_RESET_DELAY;
  endproperty
  a_reset_start: assert property (p_reset_start) else $error("reset delay missed");

  property p_reset_halt;
    @(posedge core_clk) disable iff (!reset_n)
      q.st == recloser_pkg::ST_RESET_DELAY && tc.above_min |=>
      q.st == recloser_pkg::ST_TIMING && q.tmr == 32'h0;
  endproperty
  a_reset_halt: assert property (p_reset_halt) else $error("reset delay not halted");

  property p_batt_off;
    @(posedge core_clk) disable iff (!reset_n)
      on_battery && battery_mv < recloser_pkg::BATT_LOW_MV |=> shutdown;
  endproperty
  a_batt_off: assert property (p_batt_off) else $error("no low battery shutdown");

  property p_ac_on;
    @(posedge core_clk) disable iff (!reset_n)
      ac_present |=> ac_led ##1 (ac_led || !$past(ac_present));
  endproperty
  a_ac_on: assert property (p_ac_on) else $error("ac indicator late");

  c_trip: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(trip_batt_drive));
  c_lockout: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(lockout_ind));
  c_home: cover property (@(posedge core_clk) disable iff (!reset_n)
    q.st == recloser_pkg::ST_RESET_DELAY ##1 q.st == recloser_pkg::ST_HOME);
endmodule : recloser_sequencer
`default_nettype wire

// File: pkg/recloser_pkg.sv
// Constants shared by the recloser trip and reclose sequencer.
// Assumes a 50 MHz core clock and a 60 Hz line.
`default_nettype none
package recloser_pkg;
  // ************************************************
  // Clock and timing
  // ************************************************
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned LINE_HZ = 60;
  localparam int unsigned SAMPLES_PER_CYCLE = 32;
  localparam int unsigned SAMPLE_CLKS = CLK_HZ / (LINE_HZ * SAMPLES_PER_CYCLE);
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_CLKS = CLK_HZ / MS_PER_S;
  localparam int unsigned SEC_CLKS = CLK_HZ;
  localparam int unsigned AC_OFF_S = 15;
  localparam int unsigned AC_OFF_CLKS = AC_OFF_S * CLK_HZ;
  // ************************************************
  // Analog front end
  // ************************************************
  localparam int unsigned NUM_ANALOG = 16;
  localparam int unsigned ADC_W = 16;
  localparam int unsigned NUM_CT = 3;
  localparam int unsigned NUM_VOLT = 6;
  localparam logic [3:0] CH_GROUND = 4'h3;
  localparam logic [3:0] CH_VSRC0 = 4'h4;
  localparam logic [3:0] CH_VLOAD0 = 4'h7;
  localparam logic [3:0] CH_LAST = 4'hf;
  localparam logic [4:0] PHASE_HALF = 5'h0f;
  localparam logic [4:0] PHASE_LAST = 5'h1f;
  localparam int unsigned DC_SHIFT = 5;
  // ************************************************
  // Battery, clock and sequence
  // ************************************************
  localparam logic [15:0] BATT_LOW_MV = 16'h58ac;
  localparam logic [31:0] RTC_EPOCH = 32'h0000_0000;
  localparam logic [2:0] MAX_OPS = 3'h4;
  typedef enum logic [6:0] {
    ST_HOME = 7'h01,
    ST_TIMING = 7'h02,
    ST_TRIP = 7'h04,
    ST_RECLOSE_WAIT = 7'h08,
    ST_CLOSE = 7'h10,
    ST_RESET_DELAY = 7'h20,
    ST_LOCKOUT = 7'h40
  } seq_state_e;
endpackage : recloser_pkg
`default_nettype wire

// File: pkg/trip_curve_if.sv
// Carrier between the sequencer and the overcurrent integrator.
// Assumes both ends share core_clk.
`timescale 1ns/1ps
`default_nettype none
interface trip_curve_if;
  logic smp_valid;
  logic [1:0] smp_chan;
  logic [4:0] smp_phase;
  logic signed [15:0] smp_data;
  logic clear_acc;
  logic [31:0] curve_limit;
  logic [15:0] min_trip_phase;
  logic [15:0] min_trip_ground;
  logic above_min;
  logic curve_done;
  modport seq (output smp_valid, smp_chan, smp_phase, smp_data, clear_acc,
    curve_limit, min_trip_phase, min_trip_ground, input above_min, curve_done);
  modport calc (input smp_valid, smp_chan, smp_phase, smp_data, clear_acc,
    curve_limit, min_trip_phase, min_trip_ground, output above_min, curve_done);
endinterface : trip_curve_if
`default_nettype wire

// File: tb/mechanism_model.sv
// Behavioural recloser mechanism with its current and voltage front end.
// Assumes the bench sets fault_amp and that core_clk is shared with the design.
`timescale 1ns/1ps
`default_nettype none
module mechanism_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [15:0] fault_amp,
  input wire logic adc_start,
  input wire logic [3:0] adc_chan,
  output logic adc_valid,
  output logic signed [15:0] adc_data,
  input wire logic trip_batt_drive,
  input wire logic trip_cap_drive,
  input wire logic close_drive,
  output logic open_sense,
  output logic closed_sense
);
  logic [4:0] phase_ff;
  logic [2:0] op_ff;
  logic open_ff;
  assign open_sense = open_ff;
  assign closed_sense = !open_ff;
  always @(posedge core_clk) begin
    adc_valid <= 1'b0;
    // Idle bus never holds the last result
    adc_data <= ~adc_data;
    if (!reset_n) begin
      phase_ff <= 5'h00;
      op_ff <= 3'h0;
      open_ff <= 1'b0;
      adc_data <= 16'h0000;
    end else begin
      if (adc_start) begin
        adc_valid <= 1'b1;
        if (adc_chan == 4'h0) phase_ff <= phase_ff + 5'h01;
        // Currents swing around zero so no DC hides the fault
        // An open recloser carries no line current
        if (adc_chan < 4'h4) adc_data <= open_ff ? 16'h0000 : (phase_ff[4] ? -fault_amp : fault_amp);
        else adc_data <= {12'h0a5, adc_chan};
      end
      // Opens only when both energy sources feed the solenoid
      if (open_ff ? close_drive : (trip_batt_drive && trip_cap_drive)) begin
        op_ff <= op_ff + 3'h1;
        if (op_ff == 3'h4) begin
          open_ff <= !open_ff;
          op_ff <= 3'h0;
        end
      end else begin
        op_ff <= 3'h0;
      end
    end
  end
endmodule : mechanism_model
`default_nettype wire

// File: tb/recloser_trip_reclose_sequencer_tb.sv
// Self-checking bench for the recloser trip and reclose sequencer.
// Assumes shortened timing parameters and the behavioural mechanism model.
`timescale 1ns/1ps
`default_nettype none
module recloser_trip_reclose_sequencer_tb;
  localparam int SCLK = 80;
  // Long enough ms that the half-cycle magnitude settles within a reclose interval
  localparam int MSC = 320;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic adc_start, adc_valid, open_sense, closed_sense, trip_batt_drive, trip_cap_drive;
  logic close_drive, lockout_ind, above_min_ind, shutdown, ac_led;
  logic [3:0] adc_chan;
  logic signed [15:0] adc_data;
  logic [15:0] wave_rd_data, fault_amp = 16'h0000;
  logic [31:0] rtc_seconds;
  logic [2:0] trip_count;
  logic [8:0] wave_rd_addr = 9'h000;
  logic [15:0] min_trip_phase = 16'h0100, min_trip_ground = 16'h0100;
  logic [3:0][31:0] curve_limits = {4{32'h0000_0100}};
  logic [2:0][15:0] reclose_interval_ms = {3{16'h000a}};
  logic [15:0] reset_delay_ms = 16'h000c, battery_mv = 16'h6000;
  logic [2:0] trips_to_lockout = 3'h2;
  logic panel_close_req = 1'b0, link_close_req = 1'b0, on_battery = 1'b0;
  logic ctrl_power_lost = 1'b0, rtc_set = 1'b0, ac_present = 1'b0;
  logic [31:0] rtc_value = 32'h0000_0000;
  int err_count = 0;
  int n_checks = 0;

  recloser_sequencer #(.SAMPLE_CLKS(32'(SCLK)), .MS_CLKS(32'(MSC)), .SEC_CLKS(32'h0000_000a),
    .AC_OFF_CLKS(32'h0000_0014)) dut (.core_clk, .reset_n, .adc_start, .adc_chan, .adc_valid,
    .adc_data, .wave_rd_addr, .wave_rd_data, .min_trip_phase, .min_trip_ground, .curve_limits,
    .reclose_interval_ms, .reset_delay_ms, .trips_to_lockout, .open_sense, .closed_sense,
    .panel_close_req, .link_close_req, .trip_batt_drive, .trip_cap_drive, .close_drive,
    .lockout_ind, .above_min_ind, .trip_count, .on_battery, .battery_mv, .shutdown,
    .ctrl_power_lost, .rtc_set, .rtc_value, .rtc_seconds, .ac_present, .ac_led);
  mechanism_model mech (.core_clk, .reset_n, .fault_amp, .adc_start, .adc_chan, .adc_valid,
    .adc_data, .trip_batt_drive, .trip_cap_drive, .close_drive, .open_sense, .closed_sense);

  always #10 core_clk = ~core_clk;

  // ************************************************
  // Shared tasks
  // ************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic give_verdict;
    $display("Checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  task automatic do_trip(input logic [2:0] cnt);
    int n = 0;
    while (!trip_batt_drive && n < 8000) begin tick(1); n++; end
    chk("trip cap drive", 1, trip_cap_drive);
    chk("above min at trip", 1, above_min_ind);
    while (!open_sense && n < 8100) begin tick(1); n++; end
    tick(1);
    chk("trip count", cnt, trip_count);
  endtask : do_trip
  task automatic do_reclose;
    int n = 0;
    while (!close_drive && n < 16 * MSC) begin tick(1); n++; end
    // Interval of 10 ms, one ms tick of slack below and two above
    chk("reclose delay", 1, n >= 9 * MSC && n <= 12 * MSC);
    while (!closed_sense && n < 17 * MSC) begin tick(1); n++; end
  endtask : do_reclose
  task automatic wait_below;
    int n = 0;
    while (above_min_ind !== 1'b0 && n < 4 * SCLK * 32) begin tick(1); n++; end
    chk("below min", 0, above_min_ind);
  endtask : wait_below

  // ************************************************
  // Scenarios
  // ************************************************
  task automatic t_reset;
    chk("idle drives", 0, {trip_batt_drive, trip_cap_drive, close_drive, lockout_ind});
    chk("idle house", 0, {shutdown, ac_led, adc_start, trip_count});
    chk("rtc idle", 0, rtc_seconds);
  endtask : t_reset
  task automatic t_sampling;
    int n = 0, c0 = 0, i;
    while (!(adc_start && adc_chan == 4'h0) && n < 4 * SCLK) begin tick(1); n++; end
    n = 0;
    for (i = 0; i < 32 * SCLK; i++) begin
      if (adc_start) n++;
      if (adc_start && adc_chan == 4'h0) c0++;
      tick(1);
    end
    chk("samples per cycle", 32, c0);
    chk("conversions per cycle", 32 * 16, n);
  endtask : t_sampling
  task automatic t_wave;
    logic [3:0] c;
    for (c = 4'h4; c <= 4'h9; c++) begin
      wave_rd_addr = {c, 5'h03};
      tick(2);
      chk("voltage sample", {12'h0a5, c}, wave_rd_data);
    end
  endtask : t_wave
  task automatic t_ac;
    ac_present = 1'b1;
    tick(1);
    chk("ac on at once", 1, ac_led);
    ac_present = 1'b0;
    tick(18);
    chk("ac held", 1, ac_led);
    tick(4);
    chk("ac off after timeout", 0, ac_led);
    ac_present = 1'b1;
    tick(1);
    chk("ac back", 1, ac_led);
  endtask : t_ac
  task automatic t_rtc;
    rtc_value = 32'h0000_1000;
    rtc_set = 1'b1;
    tick(1);
    rtc_set = 1'b0;
    tick(25);
    chk("rtc runs", 1, rtc_seconds > 32'h0000_1000);
    ctrl_power_lost = 1'b1;
    tick(1);
    ctrl_power_lost = 1'b0;
    chk("rtc epoch", 0, rtc_seconds);
  endtask : t_rtc
  task automatic t_close_ignored;
    int n = 0, i;
    {panel_close_req, link_close_req} = 2'b11;
    for (i = 0; i < 20; i++) begin
      if (close_drive) n++;
      if (i == 1) {panel_close_req, link_close_req} = 2'b00;
      tick(1);
    end
    chk("close outside lockout", 0, n);
  endtask : t_close_ignored
  task automatic t_temporary;
    int n = 0;
    fault_amp = 16'h0300;
    do_trip(3'h1);
    fault_amp = 16'h0000;
    do_reclose();
    wait_below();
    tick(8 * MSC);
    chk("reset delay running", 1, trip_count);
    while (trip_count !== 3'h0 && n < 8 * MSC) begin tick(1); n++; end
    chk("home after reset delay", 0, trip_count);
  endtask : t_temporary
  task automatic t_persistent;
    int n = 0, i;
    fault_amp = 16'h0300;
    do_trip(3'h1);
    do_reclose();
    do_trip(3'h2);
    while (!lockout_ind && n < 40) begin tick(1); n++; end
    chk("lockout", 1, lockout_ind);
    n = 0;
    for (i = 0; i < 300; i++) begin
      if (close_drive) n++;
      tick(1);
    end
    chk("no close in lockout", 0, {n[30:0], closed_sense});
    fault_amp = 16'h0000;
    wait_below();
    panel_close_req = 1'b1;
    tick(1);
    panel_close_req = 1'b0;
    n = 0;
    while (!close_drive && n < 10) begin tick(1); n++; end
    chk("panel close", 1, close_drive);
    while (!closed_sense && n < 40) begin tick(1); n++; end
    tick(2);
    chk("sequence restart", 0, {lockout_ind, trip_count});
  endtask : t_persistent
  task automatic t_battery;
    on_battery = 1'b1;
    battery_mv = 16'h58ac;
    tick(3);
    chk("battery at limit", 0, shutdown);
    battery_mv = 16'h58ab;
    tick(2);
    chk("battery low", 1, shutdown);
  endtask : t_battery

  // ************************************************
  // Main sequence and watchdog
  // ************************************************
  initial begin
    repeat (12) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    tick(1);
    t_reset();
    t_sampling();
    t_wave();
    t_ac();
    t_rtc();
    t_close_ignored();
    t_temporary();
    t_persistent();
    t_battery();
    give_verdict();
  end
  // Whole run needs well under 40000 cycles
  initial begin
    #(20 * 80000);
    err_count++;
    give_verdict();
  end
endmodule : recloser_trip_reclose_sequencer_tb
`default_nettype wire
